// ---- rtl/hbsw_pkg.sv ----
// package: constants and carrier types of the buffer status write-back engine
`default_nettype none
package hbsw_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses on apb)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL      = 8'h00; // inhibits and activate
   localparam logic [7:0] ADDR_TX_LOC    = 8'h04; // where the tx message pointer lives
   localparam logic [7:0] ADDR_RX_LOC    = 8'h08; // where the rx message pointer lives
   localparam logic [7:0] ADDR_LIMIT     = 8'h0C; // rx length limit, 0 = no check
   localparam logic [7:0] ADDR_STATUS    = 8'h10; // engine state
   localparam logic [7:0] ADDR_LAST_STAT = 8'h14; // last status word built
   localparam logic [7:0] ADDR_BUF_PTR   = 8'h18; // data pointer of new descriptor
   // ctrl bit positions
   localparam int CTRL_TX_INH  = 0;
   localparam int CTRL_RX_INH  = 1;
   localparam int CTRL_ACTIVATE = 2;
   // ------------------------------------------------------------
   // descriptor layout in shared memory
   // ------------------------------------------------------------
   localparam logic [31:0] DESC_BUF_OFF  = 32'h0000_0000; // buffer descriptor word
   localparam logic [31:0] DESC_DATA_OFF = 32'h0000_0004; // data buffer pointer
   localparam logic [31:0] DESC_NEXT_OFF = 32'h0000_0008; // next descriptor pointer
   localparam int BIT_OWNER = 31;
   localparam int BIT_POLL_DISABLE = 30;
   localparam int BIT_EOM   = 29;
   localparam int CNT_MSB   = 13;
   localparam int ERR_LSB   = 16;
   // receive error codes
   localparam logic [3:0] ERR_NONE     = 4'h0;
   localparam logic [3:0] ERR_OVERFLOW = 4'h1;
   localparam logic [3:0] ERR_FRAME_ALIGN = 4'h2;
   localparam logic [3:0] ERR_OOF      = 4'h8;
   localparam logic [3:0] ERR_FCS      = 4'h9;
   localparam logic [3:0] ERR_OCTET    = 4'hA;
   localparam logic [3:0] ERR_ABORT    = 4'hB;
   localparam logic [3:0] ERR_LONG     = 4'hC;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int POLL_TIME_NS  = 10000; // descriptor re-read interval
   localparam int POLL_CYCLES   = POLL_TIME_NS / CLK_PERIOD_NS;
   localparam int POLL_W        = 10;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      HBSW_IDLE  = 3'h0,
      HBSW_LDPTR = 3'h1,
      HBSW_WRST  = 3'h3,
      HBSW_RDNX  = 3'h2,
      HBSW_RDDS  = 3'h6,
      HBSW_RDBUF = 3'h7,
      HBSW_WRPTR = 3'h5,
      HBSW_POLL  = 3'h4
   } hbsw_state_t;
   // finished-buffer report from the channel logic
   typedef struct packed {
      logic        rx;            // 1 = receive direction
      logic        end_of_message_flag;           // end of message in this buffer
      logic [13:0] count;         // octets moved
      logic        overflow;      // internal buffer overflow
      logic        frame_align;   // sync misaligned with flywheel
      logic        out_of_frame_error;           // out of frame input asserted
      logic        fcs_bad;       // check sequence mismatch
      logic        octet_bad;     // payload not whole octets
      logic        abort;         // ended with abort sequence
   } hbsw_done_t;
   // shared memory master request
   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } hbsw_mem_req_t;
endpackage : hbsw_pkg
`default_nettype wire

// ---- rtl/hbsw_engine.sv ----
// module: buffer status write-back and descriptor list walker with apb registers
// How it works
// - write status over descriptor when enabled
// - tx status owner bit 31 written 0
// - rx status owner bit 31 written 1
// - tx end-of-message copied from the channel report
// - tx octet count in bits 13:0
// - rx end-of-message set on final octet
// - rx error code 19:16, count 13:0
// - code 1 on internal overflow
// - code 2 on frame sync misalignment
// - code 8 on out of frame
// - code 9 on check sequence mismatch
// - code 10 on octet misalignment, beats 9
// - code 11 on abort termination
// - overlength: end message, code 12, discard
// - next address is bits 31:2 plus 00
// - data pointer is any byte address
// - separate tx and rx inhibit controls
// - inhibit 0: status, next, read, store
// - inhibit 1: read next, store its link
// - opposite owner polarity hands buffers across
// - poll host-owned descriptor unless poll disabled
`default_nettype none
module hbsw_engine #(
   parameter int POLL_CYCLES = hbsw_pkg::POLL_CYCLES // re-read interval in cycles
) (
   // clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic [31:0]                 prdata,
   output logic                        pslverr,
   // finished buffer report from the channel logic
   input  wire logic                   done_valid,
   input  wire hbsw_pkg::hbsw_done_t   done_info,
   output logic                        done_ready,
   // shared memory master
   output var hbsw_pkg::hbsw_mem_req_t mem,
   input  wire logic                   mem_ack,
   input  wire logic [31:0]            mem_rdata,
   // results
   output logic [31:0]                 buffer_byte_pointer,
   output logic                        overlength_discard
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   // countdown width follows the interval so a long poll time cannot wrap
   localparam int POLL_W = $clog2(POLL_CYCLES + 1);
   typedef struct packed {
      hbsw_pkg::hbsw_state_t st;       // walker state
      logic                  rx;       // direction of current job
      logic                  inh;      // inhibit sampled at start
      logic [31:0]           stat;     // status word to write
      logic [31:0]           cur;      // current descriptor address
      logic [31:0]           nxt;      // next descriptor address
      logic [31:0]           link;     // link read from next descriptor
      logic [31:0]           loc;      // message pointer location
      logic [POLL_W-1:0]     poll;     // poll countdown
      logic                  parked;   // waiting for activate
      logic                  tx_inh;   // tx write-back inhibit
      logic                  rx_inh;   // rx write-back inhibit
      logic [31:0]           tx_loc;
      logic [31:0]           rx_loc;
      logic [13:0]           limit;    // rx length limit
      logic [31:0]           last;     // last status word built
      logic [31:0]           bufp;     // data buffer pointer
      logic                  discard;  // overlength pulse
      logic [31:0]           rdata;    // apb read data
      logic                  err;      // apb error
   } hbsw_regs_t;

   hbsw_regs_t r;      // registered state
   hbsw_regs_t next_r; // next state

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   // receive error code, highest priority first
   function automatic logic [3:0] rx_err_code(input hbsw_pkg::hbsw_done_t d, input logic long);
      if (long)
         rx_err_code = hbsw_pkg::ERR_LONG;
      else if (d.abort)
         rx_err_code = hbsw_pkg::ERR_ABORT;
      else if (d.octet_bad)
         rx_err_code = hbsw_pkg::ERR_OCTET;
      else if (d.fcs_bad)
         rx_err_code = hbsw_pkg::ERR_FCS;
      else if (d.out_of_frame_error)
         rx_err_code = hbsw_pkg::ERR_OOF;
      else if (d.frame_align)
         rx_err_code = hbsw_pkg::ERR_FRAME_ALIGN;
      else if (d.overflow)
         rx_err_code = hbsw_pkg::ERR_OVERFLOW;
      else
         rx_err_code = hbsw_pkg::ERR_NONE;
   endfunction

   // drop the two low bits of a pointer word
   function automatic logic [31:0] dword_addr(input logic [31:0] p);
      dword_addr = {p[31:2], 2'b00};
   endfunction

   // a memory request of the current state
   function automatic logic is_mem_state(input hbsw_pkg::hbsw_state_t s);
      is_mem_state = (s != hbsw_pkg::HBSW_IDLE) && (s != hbsw_pkg::HBSW_POLL);
   endfunction

   logic        long_msg;   // overlength on the report being taken
   logic        take;       // report accepted this cycle
   logic        apb_setup;  // apb setup phase
   logic        apb_wr;     // apb write taking effect
   logic        activate;   // software activate pulse
   logic        owner_host; // descriptor read shows host ownership

   assign done_ready = (r.st == hbsw_pkg::HBSW_IDLE);
   assign take       = done_valid && done_ready;
   assign long_msg   = done_info.rx && (r.limit != 14'h0000) && (done_info.count > r.limit);
   assign apb_setup  = psel && !penable;
   assign apb_wr     = psel && penable && pwrite;
   assign activate   = apb_wr && (paddr == hbsw_pkg::ADDR_CTRL) && pwdata[hbsw_pkg::CTRL_ACTIVATE];
   assign owner_host = mem_rdata[hbsw_pkg::BIT_OWNER];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   // one combinational pass computes everything; memory steps advance on mem_ack
   always_comb begin
      next_r         = r;
      next_r.discard = 1'b0;
      // apb register writes
      if (apb_wr) begin
         unique case (paddr)
            hbsw_pkg::ADDR_CTRL: begin
               next_r.tx_inh = pwdata[hbsw_pkg::CTRL_TX_INH];
               next_r.rx_inh = pwdata[hbsw_pkg::CTRL_RX_INH];
            end
            hbsw_pkg::ADDR_TX_LOC: next_r.tx_loc = dword_addr(pwdata);
            hbsw_pkg::ADDR_RX_LOC: next_r.rx_loc = dword_addr(pwdata);
            hbsw_pkg::ADDR_LIMIT:  next_r.limit  = pwdata[13:0];
            default: ;
         endcase
      end
      // apb read data is captured in the setup phase so it comes from a flop
      if (apb_setup) begin
         next_r.err   = 1'b0;
         next_r.rdata = 32'h0000_0000;
         unique case (paddr)
            hbsw_pkg::ADDR_CTRL:      next_r.rdata = {30'h0000_0000, r.rx_inh, r.tx_inh};
            hbsw_pkg::ADDR_TX_LOC:    next_r.rdata = r.tx_loc;
            hbsw_pkg::ADDR_RX_LOC:    next_r.rdata = r.rx_loc;
            hbsw_pkg::ADDR_LIMIT:     next_r.rdata = {18'h0_0000, r.limit};
            hbsw_pkg::ADDR_STATUS:    next_r.rdata = {27'h000_0000, r.st, r.parked, ~done_ready};
            hbsw_pkg::ADDR_LAST_STAT: next_r.rdata = r.last;
            hbsw_pkg::ADDR_BUF_PTR:   next_r.rdata = r.bufp;
            default:                  next_r.err   = 1'b1;
         endcase
      end
      // walker
      unique case (r.st)
         hbsw_pkg::HBSW_IDLE: begin
            if (take) begin
               next_r.rx  = done_info.rx;
               next_r.inh = done_info.rx ? r.rx_inh : r.tx_inh;
               next_r.loc = done_info.rx ? r.rx_loc : r.tx_loc;
               next_r.stat = 32'h0000_0000;
               if (done_info.rx) begin
                  next_r.stat[hbsw_pkg::BIT_OWNER] = 1'b1;
                  next_r.stat[hbsw_pkg::BIT_EOM]   = done_info.end_of_message_flag || long_msg;
                  next_r.stat[hbsw_pkg::ERR_LSB +: 4] = rx_err_code(done_info, long_msg);
                  next_r.stat[hbsw_pkg::CNT_MSB:0] = long_msg ? r.limit : done_info.count;
                  next_r.discard = long_msg;
               end else begin
                  next_r.stat[hbsw_pkg::BIT_OWNER] = 1'b0;
                  next_r.stat[hbsw_pkg::BIT_EOM]   = done_info.end_of_message_flag;
                  next_r.stat[hbsw_pkg::CNT_MSB:0] = done_info.count;
               end
               next_r.st = hbsw_pkg::HBSW_LDPTR;
            end
         end
         hbsw_pkg::HBSW_LDPTR: begin
            if (mem_ack) begin
               next_r.last = r.stat;
               if (r.inh) begin
                  next_r.nxt = dword_addr(mem_rdata);
                  next_r.st  = hbsw_pkg::HBSW_RDDS;
               end else begin
                  next_r.cur = dword_addr(mem_rdata);
                  next_r.st  = hbsw_pkg::HBSW_WRST;
               end
            end
         end
         hbsw_pkg::HBSW_WRST: begin
            if (mem_ack)
               next_r.st = hbsw_pkg::HBSW_RDNX;
         end
         hbsw_pkg::HBSW_RDNX: begin
            if (mem_ack) begin
               if (r.inh) begin
                  next_r.link = dword_addr(mem_rdata);
                  next_r.st   = hbsw_pkg::HBSW_WRPTR;
               end else begin
                  next_r.nxt = dword_addr(mem_rdata);
                  next_r.st  = hbsw_pkg::HBSW_RDDS;
               end
            end
         end
         hbsw_pkg::HBSW_RDDS: begin
            if (mem_ack) begin
               if (owner_host) begin
                  // host still owns it: poll, or park when polling is off
                  next_r.parked = mem_rdata[hbsw_pkg::BIT_POLL_DISABLE];
                  next_r.poll   = POLL_W'(POLL_CYCLES - 1);
                  next_r.st     = hbsw_pkg::HBSW_POLL;
               end else begin
                  next_r.st = hbsw_pkg::HBSW_RDBUF;
               end
            end
         end
         hbsw_pkg::HBSW_RDBUF: begin
            if (mem_ack) begin
               next_r.bufp = mem_rdata;
               next_r.st   = r.inh ? hbsw_pkg::HBSW_RDNX : hbsw_pkg::HBSW_WRPTR;
            end
         end
         hbsw_pkg::HBSW_WRPTR: begin
            if (mem_ack)
               next_r.st = hbsw_pkg::HBSW_IDLE;
         end
         hbsw_pkg::HBSW_POLL: begin
            // a parked walker waits for software; otherwise count down
            if (r.parked) begin
               if (activate) begin
                  next_r.parked = 1'b0;
                  next_r.st     = hbsw_pkg::HBSW_RDDS;
               end
            end else if (r.poll == '0) begin
               next_r.st = hbsw_pkg::HBSW_RDDS;
            end else begin
               next_r.poll = r.poll - POLL_W'(1);
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r    <= '0;
         r.st <= hbsw_pkg::HBSW_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // memory request is a level held until mem_ack
   always_comb begin
      mem.req   = is_mem_state(r.st);
      mem.we    = (r.st == hbsw_pkg::HBSW_WRST) || (r.st == hbsw_pkg::HBSW_WRPTR);
      mem.addr  = 32'h0000_0000;
      mem.wdata = 32'h0000_0000;
      unique case (r.st)
         hbsw_pkg::HBSW_LDPTR: mem.addr = r.loc;
         hbsw_pkg::HBSW_WRST: begin
            mem.addr  = r.cur + hbsw_pkg::DESC_BUF_OFF;
            mem.wdata = r.stat;
         end
         hbsw_pkg::HBSW_RDNX:  mem.addr = (r.inh ? r.nxt : r.cur) + hbsw_pkg::DESC_NEXT_OFF;
         hbsw_pkg::HBSW_RDDS:  mem.addr = r.nxt + hbsw_pkg::DESC_BUF_OFF;
         hbsw_pkg::HBSW_RDBUF: mem.addr = r.nxt + hbsw_pkg::DESC_DATA_OFF;
         hbsw_pkg::HBSW_WRPTR: begin
            mem.addr  = r.loc;
            mem.wdata = r.inh ? r.link : r.nxt;
         end
         default: ;
      endcase
   end

   assign pready              = 1'b1;
   assign prdata              = r.rdata;
   assign pslverr             = psel && penable && r.err;
   assign buffer_byte_pointer = r.bufp;
   assign overlength_discard  = r.discard;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_status_write;
      mem.req && mem.we && (r.st == hbsw_pkg::HBSW_WRST);
   endsequence

   property p_tx_owner;
      s_status_write and !r.rx |-> !mem.wdata[31] && (mem.wdata[28:14] == 15'h0000) && !mem.wdata[30];
   endproperty
   a_tx_owner: assert property (p_tx_owner) else $error("tx status owner or reserved bad");

   property p_rx_owner;
      s_status_write and r.rx |-> mem.wdata[31] && (mem.wdata[28:20] == 9'h000) && (mem.wdata[15:14] == 2'b00);
   endproperty
   a_rx_owner: assert property (p_rx_owner) else $error("rx status owner or reserved bad");

   property p_tx_count;
      take && !done_info.rx |=> r.stat[13:0] == $past(done_info.count) && r.stat[29] == $past(done_info.end_of_message_flag);
   endproperty
   a_tx_count: assert property (p_tx_count) else $error("tx count or end flag wrong");

   property p_octet_first;
      take && done_info.rx && done_info.octet_bad && done_info.fcs_bad && !done_info.abort && !long_msg
         |=> r.stat[19:16] == 4'hA;
   endproperty
   a_octet_first: assert property (p_octet_first) else $error("octet error must beat fcs");

   property p_long;
      take && long_msg |=> r.stat[19:16] == 4'hC && r.stat[29] && overlength_discard;
   endproperty
   a_long: assert property (p_long) else $error("overlength not reported");

   property p_inhibit_no_status;
      r.inh |-> r.st != hbsw_pkg::HBSW_WRST;
   endproperty
   a_inhibit_no_status: assert property (p_inhibit_no_status) else $error("status written while inhibited");

   property p_walk_order;
      (r.st == hbsw_pkg::HBSW_WRST) && mem_ack |=> r.st == hbsw_pkg::HBSW_RDNX ##0 mem.addr == r.cur + 32'h8;
   endproperty
   a_walk_order: assert property (p_walk_order) else $error("next pointer not fetched after status");

   property p_aligned;
      (r.st == hbsw_pkg::HBSW_RDDS) |-> mem.addr[1:0] == 2'b00;
   endproperty
   a_aligned: assert property (p_aligned) else $error("descriptor address not dword aligned");

   // cycles spent counting down; the interval may exceed any delay range
   int poll_age;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         poll_age <= 0;
      else if ((r.st == hbsw_pkg::HBSW_POLL) && !r.parked)
         poll_age <= poll_age + 1;
      else
         poll_age <= 0;
   end

   property p_poll;
      (r.st == hbsw_pkg::HBSW_POLL) && !r.parked |-> poll_age < POLL_CYCLES;
   endproperty
   a_poll: assert property (p_poll) else $error("host-owned descriptor not re-read");

endmodule : hbsw_engine
`default_nettype wire

// ---- bench/hbsw_mem_model.sv ----
// host memory model holding the descriptor lists that the engine walks
`default_nettype none
module hbsw_mem_model (
   // clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // memory port of the engine
   input  wire hbsw_pkg::hbsw_mem_req_t mem,
   output logic                         mem_ack,
   output logic [31:0]                  mem_rdata,
   // 1 = answer after three wait cycles
   input  wire logic                    slow
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] ram [64]; // word store, also set up by the bench
   logic [1:0]  wait_n;   // wait cycles spent on this access
   // ------
   // access: one-cycle ack, junk read data outside the ack cycle
   // ------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'h0;
         wait_n <= 2'h0;
         mem_rdata <= 32'h5A5A_5A5A;
      end else if (mem_ack) begin
         // gap after each ack, the data flips so stale words never match
         mem_ack <= 1'h0;
         mem_rdata <= ~mem_rdata;
      end else if (mem.req && (wait_n == 2'h3 || !slow)) begin
         mem_ack <= 1'h1;
         wait_n <= 2'h0;
         mem_rdata <= ram[mem.addr[7:2]];
         if (mem.we) ram[mem.addr[7:2]] <= mem.wdata;
      end else begin
         wait_n <= mem.req ? wait_n + 2'h1 : 2'h0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule // hbsw_mem_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the status write-back engine
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // signals
   // ------
   logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]              paddr;
   logic [31:0]             pwdata, prdata, rd, want, buffer_byte_pointer, mem_rdata;
   logic                    done_valid, done_ready, mem_ack, slow, disc_seen, last_err, overlength_discard;
   hbsw_pkg::hbsw_done_t    done_info;
   hbsw_pkg::hbsw_mem_req_t mem;
   logic [3:0]              code [7] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'hB, 4'h0};
   // flags: overflow, frame align, out of frame, check seq, octet, abort
   logic [5:0]              flg [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h06, 6'h01, 6'h00};
   int                      err_count, comparisons;
   time                     t0;
   // short poll interval keeps the run small
   hbsw_engine #(.POLL_CYCLES(8)) hbsw_engine_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .done_valid(done_valid), .done_info(done_info),
      .done_ready(done_ready), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .buffer_byte_pointer(buffer_byte_pointer), .overlength_discard(overlength_discard));
   hbsw_mem_model hm (.pclk(pclk), .presetn(presetn), .mem(mem), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .slow(slow));
   // ------
   // clock, discard pulse catcher and watchdog
   // ------
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) if (overlength_discard === 1'h1) disc_seen <= 1'h1;
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      wrap_up();
   end
   // ------
   // tasks
   // ------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
      comparisons++;
      if (got !== exp_v) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp_v);
      end
   endtask
   // one apb transfer; an edge passes first so psel is never set twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'h0; penable <= 1'h0;
   endtask
   // hand over one finished buffer and wait, bounded, for the walk to end
   task automatic job(input hbsw_pkg::hbsw_done_t d);
      int n;
      @(posedge pclk);
      done_info <= d;
      done_valid <= 1'h1;
      @(posedge pclk);
      while (done_ready !== 1'h1) @(posedge pclk);
      done_valid <= 1'h0;
      n = 0;
      @(posedge pclk);
      while (done_ready !== 1'h1 && n < 900) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n < 900), 32'h1);
   endtask
   // message pointer at 0x40 names the first descriptor, both device owned
   task automatic prep;
      hm.ram[16] = 32'h80;
      hm.ram[32] = 32'h0;
      hm.ram[40] = 32'h0;
   endtask
   task automatic wrap_up;
      $display("err_count=%0d comparisons=%0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ------
   // tests
   // ------
   initial begin
      {psel, penable, pwrite, done_valid, slow, disc_seen, last_err} = '0;
      paddr = '0; pwdata = '0; done_info = '0;
      presetn = 1'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      // ring of two descriptors, the last links back to the first; low link bits set
      hm.ram[34] = 32'hA1;
      hm.ram[42] = 32'h82;
      hm.ram[33] = 32'h1111_1113;
      hm.ram[41] = 32'h2222_2221;
      apb(1'h1, hbsw_pkg::ADDR_TX_LOC, 32'h40);
      apb(1'h1, hbsw_pkg::ADDR_RX_LOC, 32'h40);
      apb(1'h0, hbsw_pkg::ADDR_TX_LOC, 32'h0);
      chk(rd, 32'h40);
      apb(1'h0, 8'h3C, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      // transmit buffer, status written then list advanced
      prep();
      job(hbsw_pkg::hbsw_done_t'({1'h0, 1'h1, 14'h3FFF, 6'h00}));
      chk(hm.ram[32], 32'h2000_3FFF);
      chk(hm.ram[16], 32'hA0);
      chk(buffer_byte_pointer, 32'h2222_2221);
      apb(1'h0, hbsw_pkg::ADDR_LAST_STAT, 32'h0);
      chk(rd, 32'h2000_3FFF);
      // every receive error code below 12, the octet error beating the check sequence
      for (int i = 0; i < 7; i++) begin
         prep();
         job(hbsw_pkg::hbsw_done_t'({1'h1, i != 6, 14'(i + 5), flg[i]}));
         want = {1'h1, 1'h0, i != 6, 9'h0, code[i], 2'h0, 14'(i + 5)};
         chk(hm.ram[32], want);
      end
      chk({31'h0, disc_seen}, 32'h0);
      // overlength receive is cut at the limit
      apb(1'h1, hbsw_pkg::ADDR_LIMIT, 32'hA);
      prep();
      job(hbsw_pkg::hbsw_done_t'({1'h1, 1'h0, 14'h14, 6'h00}));
      chk(hm.ram[32], 32'hA00C_000A);
      chk({31'h0, disc_seen}, 32'h1);
      apb(1'h1, hbsw_pkg::ADDR_LIMIT, 32'h0);
      // receive inhibit: no status, pointer takes the descriptor's link
      apb(1'h1, hbsw_pkg::ADDR_CTRL, 32'h2);
      prep();
      hm.ram[32] = 32'h55;
      job(hbsw_pkg::hbsw_done_t'({1'h1, 1'h1, 14'h3, 6'h00}));
      chk(hm.ram[32], 32'h55);
      chk(hm.ram[16], 32'hA0);
      chk(buffer_byte_pointer, 32'h1111_1113);
      // transmit still writes status; next descriptor host owned, polled, slow memory
      prep();
      hm.ram[40] = 32'h8000_0000;
      slow <= 1'h1;
      t0 = $time;
      fork
         job(hbsw_pkg::hbsw_done_t'({1'h0, 1'h0, 14'h1, 6'h00}));
         begin
            repeat (60) @(posedge pclk);
            hm.ram[40] = 32'h0;
         end
      join
      chk(hm.ram[32], 32'h1);
      chk(hm.ram[16], 32'hA0);
      chk({31'h0, $time > t0 + 600}, 32'h1);
      // poll disabled: the walker parks until software activates it
      prep();
      hm.ram[40] = 32'hC000_0000;
      fork
         job(hbsw_pkg::hbsw_done_t'({1'h0, 1'h1, 14'h2, 6'h00}));
         begin
            repeat (60) @(posedge pclk);
            apb(1'h0, hbsw_pkg::ADDR_STATUS, 32'h0);
            chk(rd, 32'h13);
            hm.ram[40] = 32'h0;
            apb(1'h1, hbsw_pkg::ADDR_CTRL, 32'h4);
         end
      join
      chk(hm.ram[32], 32'h2000_0002);
      chk(hm.ram[16], 32'hA0);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
